// [pkg/dcdc_pkg.sv]
// Constants and types shared by the clock divider control core
package dcdc_pkg;

   // Register index; byte address is four times the index
   localparam logic [5:0] IDX_DIV   = 6'h01;
   localparam logic [5:0] IDX_MUX   = 6'h02;
   localparam logic [5:0] IDX_DAC   = 6'h08;
   localparam logic [5:0] IDX_OFF   = 6'h0E;
   localparam logic [5:0] IDX_NVCTL = 6'h10;
   localparam logic [5:0] IDX_STAT  = 6'h11;

   // Mode word field positions
   localparam int MUX_PDN_MAIN  = 14;
   localparam int MUX_PDN_REF   = 13;
   localparam int MUX_SEL_REF   = 12;
   localparam int MUX_EN_REF    = 11;
   localparam int MUX_RREF_HI   = 10;
   localparam int MUX_RREF_LO   = 9;
   localparam int MUX_RMAIN_HI  = 8;
   localparam int MUX_RMAIN_LO  = 7;
   localparam int MUX_BYPASS    = 6;
   localparam logic [15:0] MUX_WMASK = 16'h7FC0;

   // Factory defaults held in nonvolatile storage
   localparam logic [15:0] MUX_RESET = 16'h1800;
   localparam logic [9:0]  DIV_RESET = 10'h000;
   localparam logic [9:0]  DAC_RESET = 10'h1F4;
   localparam logic [4:0]  OFF_RESET = 5'h00;

   // Nonvolatile control and status bits
   localparam int NVCTL_AUTO = 0;
   localparam int NVCTL_SAVE = 1;
   localparam int STAT_DOWN  = 0;
   localparam int STAT_RUN   = 1;
   localparam int STAT_REFOE = 2;
   localparam int STAT_MAINOE = 3;
   localparam int STAT_DIRTY = 4;

   // Nonvolatile slots
   localparam int NV_WORDS  = 4;
   localparam int SLOT_DIV  = 0;
   localparam int SLOT_MUX  = 1;
   localparam int SLOT_DAC  = 2;
   localparam int SLOT_OFF  = 3;

   // Master clock cycles before outputs may enable
   localparam int STABLE_CYCLES = 8000;

   typedef enum logic [2:0] {
      PWR_LOAD,
      PWR_STABLE,
      PWR_RUN,
      PWR_DRAIN,
      PWR_DOWN
   } dcdc_pwr_t;

endpackage

// [core/dcdc_prescaler.sv]
// Power-of-two prescaler producing a one-cycle tick
module dcdc_prescaler #(
   parameter int CODE_W = 2
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              clear,
   input  wire logic [CODE_W-1:0] ratioCode,
   output logic                   tick
);
   localparam int CNT_W = (1 << CODE_W) - 1;

   if (CODE_W < 1 || CODE_W > 3) begin : g_chk
      $error("CODE_W must be 1 to 3");
   end

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] mask;

   // Code n gives a tick every 2**n cycles
   always_comb begin
      mask = CNT_W'((1 << ratioCode) - 1);
   end

   assign tick = ce && !clear && ((cnt_reg & mask) == mask);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (ce) begin
         if (clear) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule

// [core/dcdc_top.sv]
// Dual-output clock divider, enable and power-down control core
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
module dcdc_top #(
   parameter int STABLE_CYCLES = dcdc_pkg::STABLE_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        refControlPin,
   input  wire logic        mainControlPin,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             referenceClockOut,
   output logic             referenceClockOe,
   output logic             mainClockOut,
   output logic             mainClockOe,
   output logic             oscRun,
   output logic      [9:0]  freqCode,
   output logic      [4:0]  freqOffset
);
   if (STABLE_CYCLES < 2 || STABLE_CYCLES > 65535) begin : g_chk
      $error("STABLE_CYCLES out of range");
   end

   logic [1:0]          pinMeta_reg;
   logic [1:0]          pinSync_reg;
   logic                refCtrl;
   logic                mainCtrl;
   logic                waitReq_reg;
   logic [31:0]         readData_reg;
   logic [31:0]         readMux;
   logic                busReq;
   logic                busAck;
   logic                wrEn;
   logic                saveReq;
   logic [5:0]          regIdx;
   logic [9:0]          divValue_reg;
   logic [15:0]         muxWord_reg;
   logic [9:0]          freqCode_reg;
   logic [4:0]          offset_reg;
   logic                autoSave_reg;
   logic                nvDirty_reg;
   logic [15:0]         nvMem [0:dcdc_pkg::NV_WORDS-1];
   logic                refEnableModeBit;
   logic                refSelectBit;
   logic                refPowerdownBit;
   logic                mainPowerdownBit;
   logic                dividerBypassBit;
   logic [1:0]          refRatio;
   logic [1:0]          mainRatio;
   dcdc_pkg::dcdc_pwr_t pwrState_reg;
   logic [15:0]         stableCnt_reg;
   logic                shutdownReq;
   logic                runAllowed;
   logic                refPre;
   logic                refWant;
   logic                mainWant;
   logic                refOe_reg;
   logic                refPhase_reg;
   logic                mainOe_reg;
   logic                mainPhase_reg;
   logic                oscRun_reg;
   logic                p0Tick;
   logic                p1Tick;
   logic                refTick;
   logic                nTick;
   logic [10:0]         nCnt_reg;
   logic [10:0]         nLimit;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Control pin synchronisers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
      end else if (ce) begin
         pinMeta_reg <= {mainControlPin, refControlPin};
         pinSync_reg <= pinMeta_reg;
      end
   end
   assign refCtrl  = pinSync_reg[0];
   assign mainCtrl = pinSync_reg[1];

   // Mode word fields
   assign refEnableModeBit = muxWord_reg[dcdc_pkg::MUX_EN_REF];
   assign refSelectBit     = muxWord_reg[dcdc_pkg::MUX_SEL_REF];
   assign refPowerdownBit  = muxWord_reg[dcdc_pkg::MUX_PDN_REF];
   assign mainPowerdownBit = muxWord_reg[dcdc_pkg::MUX_PDN_MAIN];
   assign dividerBypassBit = muxWord_reg[dcdc_pkg::MUX_BYPASS];
   assign refRatio  = {muxWord_reg[dcdc_pkg::MUX_RREF_HI],
                       muxWord_reg[dcdc_pkg::MUX_RREF_LO]};
   assign mainRatio = {muxWord_reg[dcdc_pkg::MUX_RMAIN_HI],
                       muxWord_reg[dcdc_pkg::MUX_RMAIN_LO]};

   // Avalon slave: one wait cycle, then the access completes
   assign busReq  = avs_read | avs_write;
   assign busAck  = busReq && !waitReq_reg;
   assign regIdx  = avs_address[7:2];
   // Programming is locked out while powered down
   assign wrEn    = avs_write && busAck && ce &&
                    (pwrState_reg != dcdc_pkg::PWR_DOWN);
   assign saveReq = wrEn && (regIdx == dcdc_pkg::IDX_NVCTL) &&
                    avs_writedata[dcdc_pkg::NVCTL_SAVE];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         waitReq_reg <= 1'b1;
      end else if (ce) begin
         waitReq_reg <= !(busReq && waitReq_reg);
      end
   end

   always_comb begin
      readMux = '0;
      case (regIdx)
         dcdc_pkg::IDX_DIV:   readMux[9:0]  = divValue_reg;
         dcdc_pkg::IDX_MUX:   readMux[15:0] = muxWord_reg;
         dcdc_pkg::IDX_DAC:   readMux[9:0]  = freqCode_reg;
         dcdc_pkg::IDX_OFF:   readMux[4:0]  = offset_reg;
         dcdc_pkg::IDX_NVCTL: readMux[dcdc_pkg::NVCTL_AUTO] = autoSave_reg;
         dcdc_pkg::IDX_STAT: begin
            readMux[dcdc_pkg::STAT_DOWN] =
               (pwrState_reg == dcdc_pkg::PWR_DOWN);
            readMux[dcdc_pkg::STAT_RUN] =
               (pwrState_reg == dcdc_pkg::PWR_RUN);
            readMux[dcdc_pkg::STAT_REFOE]  = refOe_reg;
            readMux[dcdc_pkg::STAT_MAINOE] = mainOe_reg;
            readMux[dcdc_pkg::STAT_DIRTY]  = nvDirty_reg;
         end
         default: readMux = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         readData_reg <= '0;
      end else if (ce && busReq && waitReq_reg) begin
         readData_reg <= readMux;
      end
   end

   // Live settings: recalled from storage, then host-programmable
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         divValue_reg <= dcdc_pkg::DIV_RESET;
         muxWord_reg  <= dcdc_pkg::MUX_RESET;
         freqCode_reg <= dcdc_pkg::DAC_RESET;
         offset_reg   <= dcdc_pkg::OFF_RESET;
         autoSave_reg <= 1'b1;
      end else if (ce && pwrState_reg == dcdc_pkg::PWR_LOAD) begin
         divValue_reg <= nvMem[dcdc_pkg::SLOT_DIV][9:0];
         muxWord_reg  <= nvMem[dcdc_pkg::SLOT_MUX];
         freqCode_reg <= nvMem[dcdc_pkg::SLOT_DAC][9:0];
         offset_reg   <= nvMem[dcdc_pkg::SLOT_OFF][4:0];
      end else if (wrEn) begin
         case (regIdx)
            dcdc_pkg::IDX_DIV: divValue_reg <= avs_writedata[9:0];
            dcdc_pkg::IDX_MUX:
               muxWord_reg <= avs_writedata[15:0] & dcdc_pkg::MUX_WMASK;
            dcdc_pkg::IDX_DAC: freqCode_reg <= avs_writedata[9:0];
            dcdc_pkg::IDX_OFF: offset_reg <= avs_writedata[4:0];
            dcdc_pkg::IDX_NVCTL:
               autoSave_reg <= avs_writedata[dcdc_pkg::NVCTL_AUTO];
            default: ;
         endcase
      end
   end

   // Nonvolatile copy of the settings
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         nvMem[dcdc_pkg::SLOT_DIV] <= {6'h00, dcdc_pkg::DIV_RESET};
         nvMem[dcdc_pkg::SLOT_MUX] <= dcdc_pkg::MUX_RESET;
         nvMem[dcdc_pkg::SLOT_DAC] <= {6'h00, dcdc_pkg::DAC_RESET};
         nvMem[dcdc_pkg::SLOT_OFF] <= {11'h000, dcdc_pkg::OFF_RESET};
         nvDirty_reg <= 1'b0;
      end else if (saveReq) begin
         nvMem[dcdc_pkg::SLOT_DIV] <= {6'h00, divValue_reg};
         nvMem[dcdc_pkg::SLOT_MUX] <= muxWord_reg;
         nvMem[dcdc_pkg::SLOT_DAC] <= {6'h00, freqCode_reg};
         nvMem[dcdc_pkg::SLOT_OFF] <= {11'h000, offset_reg};
         nvDirty_reg <= 1'b0;
      end else if (wrEn && regIdx != dcdc_pkg::IDX_NVCTL &&
                   regIdx != dcdc_pkg::IDX_STAT) begin
         if (autoSave_reg) begin
            case (regIdx)
               dcdc_pkg::IDX_DIV: nvMem[dcdc_pkg::SLOT_DIV] <=
                  {6'h00, avs_writedata[9:0]};
               dcdc_pkg::IDX_MUX: nvMem[dcdc_pkg::SLOT_MUX] <=
                  avs_writedata[15:0] & dcdc_pkg::MUX_WMASK;
               dcdc_pkg::IDX_DAC: nvMem[dcdc_pkg::SLOT_DAC] <=
                  {6'h00, avs_writedata[9:0]};
               dcdc_pkg::IDX_OFF: nvMem[dcdc_pkg::SLOT_OFF] <=
                  {11'h000, avs_writedata[4:0]};
               default: ;
            endcase
         end else if (regIdx == dcdc_pkg::IDX_DIV ||
                      regIdx == dcdc_pkg::IDX_MUX ||
                      regIdx == dcdc_pkg::IDX_DAC ||
                      regIdx == dcdc_pkg::IDX_OFF) begin
            nvDirty_reg <= 1'b1;
         end
      end
   end

   // Power-down request from either gated pin
   assign shutdownReq = (refPowerdownBit && refCtrl) ||
                        (mainPowerdownBit && mainCtrl) ||
                        (!refEnableModeBit && !refSelectBit &&
                         !refPowerdownBit && refCtrl);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pwrState_reg  <= dcdc_pkg::PWR_LOAD;
         stableCnt_reg <= '0;
      end else if (ce) begin
         case (pwrState_reg)
            dcdc_pkg::PWR_LOAD: begin
               pwrState_reg  <= dcdc_pkg::PWR_STABLE;
               stableCnt_reg <= '0;
            end
            dcdc_pkg::PWR_STABLE: begin
               if (shutdownReq) begin
                  pwrState_reg <= dcdc_pkg::PWR_DOWN;
               end else if (stableCnt_reg ==
                            16'(STABLE_CYCLES - 1)) begin
                  pwrState_reg <= dcdc_pkg::PWR_RUN;
               end else begin
                  stableCnt_reg <= stableCnt_reg + 16'h0001;
               end
            end
            dcdc_pkg::PWR_RUN: begin
               if (shutdownReq) begin
                  pwrState_reg <= dcdc_pkg::PWR_DRAIN;
               end
            end
            // Outputs finish their high phase before the stop
            dcdc_pkg::PWR_DRAIN: begin
               if (!refOe_reg && !mainOe_reg) begin
                  pwrState_reg <= dcdc_pkg::PWR_DOWN;
               end
            end
            dcdc_pkg::PWR_DOWN: begin
               if (!shutdownReq) begin
                  pwrState_reg  <= dcdc_pkg::PWR_STABLE;
                  stableCnt_reg <= '0;
               end
            end
            default: pwrState_reg <= dcdc_pkg::PWR_LOAD;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         oscRun_reg <= 1'b1;
      end else if (ce) begin
         oscRun_reg <= (pwrState_reg != dcdc_pkg::PWR_DOWN);
      end
   end

   // Reference pin function by mode bits
   assign runAllowed = (pwrState_reg == dcdc_pkg::PWR_RUN);
   always_comb begin
      refPre  = refSelectBit;
      refWant = 1'b0;
      if (refPowerdownBit) begin
         refWant = !refCtrl;
      end else if (refEnableModeBit) begin
         refWant = !refCtrl;
      end else if (refSelectBit) begin
         refWant = 1'b1;
         refPre  = refCtrl;
      end else begin
         refWant = 1'b0;
      end
      refWant = refWant && runAllowed;
   end
   assign mainWant = !mainCtrl && runAllowed;

   // Both paths run from the one master clock
   dcdc_prescaler #(
      .CODE_W(2)
   ) refPrescaler (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .clear    (!refOe_reg),
      .ratioCode(refRatio),
      .tick     (p0Tick)
   );

   dcdc_prescaler #(
      .CODE_W(2)
   ) mainPrescaler (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .clear    (!mainOe_reg),
      .ratioCode(mainRatio),
      .tick     (p1Tick)
   );

   assign refTick = ce && (refPre ? p0Tick : 1'b1);
   assign nLimit  = {1'b0, divValue_reg} + 11'h001;
   assign nTick   = dividerBypassBit ? p1Tick :
                    (p1Tick && nCnt_reg >= nLimit);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         nCnt_reg <= '0;
      end else if (ce) begin
         if (!mainOe_reg || dividerBypassBit) begin
            nCnt_reg <= '0;
         end else if (p1Tick) begin
            nCnt_reg <= (nCnt_reg >= nLimit) ? 11'h000 :
                        nCnt_reg + 11'h001;
         end
      end
   end

   // Enable starts low from cleared counters; disable waits for low
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         refOe_reg    <= 1'b0;
         refPhase_reg <= 1'b0;
      end else if (ce) begin
         if (!refOe_reg) begin
            refPhase_reg <= 1'b0;
            refOe_reg    <= refWant;
         end else if (!refWant && !refPhase_reg) begin
            refOe_reg <= 1'b0;
         end else if (refTick) begin
            refPhase_reg <= !refPhase_reg;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mainOe_reg    <= 1'b0;
         mainPhase_reg <= 1'b0;
      end else if (ce) begin
         if (!mainOe_reg) begin
            mainPhase_reg <= 1'b0;
            mainOe_reg    <= mainWant;
         end else if (!mainWant && !mainPhase_reg) begin
            mainOe_reg <= 1'b0;
         end else if (nTick) begin
            mainPhase_reg <= !mainPhase_reg;
         end
      end
   end

   assign avs_readdata      = readData_reg;
   assign avs_waitrequest   = waitReq_reg;
   assign referenceClockOut = refPhase_reg;
   assign referenceClockOe  = refOe_reg;
   assign mainClockOut      = mainPhase_reg;
   assign mainClockOe       = mainOe_reg;
   assign oscRun            = oscRun_reg;
   assign freqCode          = freqCode_reg;
   assign freqOffset        = offset_reg;

   property p_en_low;
      $rose(mainOe_reg) |-> !mainPhase_reg && !$past(mainPhase_reg);
   endproperty
   a_en_low: assert property (p_en_low)
      else $error("enable not low");

   property p_dis_low;
      $fell(refOe_reg) |-> !$past(refPhase_reg) && !refPhase_reg;
   endproperty
   a_dis_low: assert property (p_dis_low)
      else $error("disable high");

   property p_down_off;
      pwrState_reg == dcdc_pkg::PWR_DOWN |-> !refOe_reg && !mainOe_reg
         && nCnt_reg == 11'h000;
   endproperty
   a_down_off: assert property (p_down_off)
      else $error("down active");

   property p_stable;
      $rose(pwrState_reg == dcdc_pkg::PWR_RUN) |->
         $past(stableCnt_reg) == 16'(STABLE_CYCLES - 1);
   endproperty
   a_stable: assert property (p_stable) else $error("early run");

   property p_shut;
      ce && pwrState_reg == dcdc_pkg::PWR_RUN &&
         ((refCtrl && refPowerdownBit) || (mainCtrl && mainPowerdownBit))
         |=> pwrState_reg == dcdc_pkg::PWR_DRAIN;
   endproperty
   a_shut: assert property (p_shut) else $error("no shutdown");

   property p_div2;
      nTick && !dividerBypassBit && mainRatio == 2'b00 &&
         divValue_reg == 10'h000 |=> !nTick ##1 (nTick || !mainOe_reg
         || !ce || !$stable(muxWord_reg));
   endproperty
   a_div2: assert property (p_div2) else $error("divide by two bad");

   property p_bypass;
      dividerBypassBit |-> nTick == p1Tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass bad");

   property p_mux;
      runAllowed && !refEnableModeBit && refSelectBit && !refPowerdownBit
         |-> refPre == refCtrl && refWant;
   endproperty
   a_mux: assert property (p_mux) else $error("mux select bad");

   property p_main_oe;
      runAllowed && mainCtrl |-> !mainWant;
   endproperty
   a_main_oe: assert property (p_main_oe) else $error("main oe bad");

   property p_osc_stop;
      (pwrState_reg == dcdc_pkg::PWR_DOWN)[*2] |-> !oscRun_reg;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("osc runs");

   property p_autosave;
      wrEn && autoSave_reg && regIdx == dcdc_pkg::IDX_DAC |=>
         nvMem[dcdc_pkg::SLOT_DAC][9:0] == $past(avs_writedata[9:0]);
   endproperty
   a_autosave: assert property (p_autosave) else $error("no save");

   c_ref_en: cover property ($rose(refOe_reg));
   c_down: cover property ($rose(pwrState_reg == dcdc_pkg::PWR_DOWN));
   c_save: cover property (saveReq);
   c_bypass: cover property (nTick && dividerBypassBit && mainOe_reg);
endmodule

// [testbench/dcdc_host_model.sv]
// Host model: drives both control pins, resolves the two clock pins
module dcdc_host_model (
   input  wire logic ref_clk,
   input  wire logic refWant,
   input  wire logic mainWant,
   input  wire logic refOut,
   input  wire logic refOe,
   input  wire logic mainOut,
   input  wire logic mainOe,
   output logic      refControlPin,
   output logic      mainControlPin,
   output wire       refPin,
   output wire       mainPin
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge ref_clk) begin
      refControlPin  <= refWant;
      mainControlPin <= mainWant;
   end
   assign refPin  = refOe ? refOut : 1'bz;
   assign mainPin = mainOe ? mainOut : 1'bz;
endmodule

// [testbench/dcdc_top_bench.sv]
// Self-checking bench for the clock divider control core
module dcdc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk, rst_n, refWant, mainWant, refCtl, mainCtl;
   logic [7:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        refOut, refOe, mainOut, mainOe, oscRun;
   logic [9:0]  freqCode;
   logic [4:0]  freqOffset;
   wire         refPin, mainPin;
   int          bad_count, num_checks, cycles, n;

   dcdc_top #(.STABLE_CYCLES(16)) dcdc_top_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
      .refControlPin(refCtl), .mainControlPin(mainCtl),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .referenceClockOut(refOut), .referenceClockOe(refOe),
      .mainClockOut(mainOut), .mainClockOe(mainOe), .oscRun(oscRun),
      .freqCode(freqCode), .freqOffset(freqOffset));
   dcdc_host_model dcdc_host_model_i (
      .ref_clk(ref_clk), .refWant(refWant), .mainWant(mainWant),
      .refOut(refOut), .refOe(refOe), .mainOut(mainOut),
      .mainOe(mainOe), .refControlPin(refCtl),
      .mainControlPin(mainCtl), .refPin(refPin), .mainPin(mainPin));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic complete_run;
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Disable, apply mode, enable, then time first rise and high level
   task automatic run(input bit isMain, input logic [31:0] mode, int k);
      refWant  <= 1'b1;
      mainWant <= 1'b1;
      bus(1'b1, 8'h08, mode);
      do begin
         rd[0] = isMain ? mainOut : refOut;
         @(negedge ref_clk);
      end while ((isMain ? mainOe : refOe) !== 1'b0);
      chk(rd[0], 1'b0);
      @(posedge ref_clk);
      if (isMain) mainWant <= 1'b0;
      else refWant <= 1'b0;
      do @(negedge ref_clk); while ((isMain ? mainOe : refOe) !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while ((isMain ? mainPin : refPin) !== 1'b1);
      chk(n, k);
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while ((isMain ? mainPin : refPin) !== 1'b0);
      chk(n, k);
      @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run;
      end
   end

   initial begin
      bad_count = 0;
      num_checks = 0;
      cycles = 0;
      rst_n = 1'b0;
      refWant = 1'b1;
      mainWant = 1'b1;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk(freqCode, 10'h1F4);
      chk(freqOffset, 5'h00);
      bus(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h1800);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'hFC, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 8'h20, 32'h2A5);
      bus(1'b1, 8'h38, 32'h13);
      chk(freqCode, 10'h2A5);
      chk(freqOffset, 5'h13);
      for (int r = 0; r < 4; r++)
         run(1'b0, 32'h1800 | (r << 9), 1 << r);
      run(1'b0, 32'h0800, 1);
      for (int m = 0; m < 4; m++)
         run(1'b1, 32'h1840 | (m << 7), 1 << m);
      bus(1'b1, 8'h04, 32'h3);
      run(1'b1, 32'h1880, 10);
      bus(1'b1, 8'h04, 32'h0);
      run(1'b1, 32'h1800, 2);
      bus(1'b1, 8'h08, 32'h1400);
      do @(negedge ref_clk); while (refPin !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end while (refPin !== 1'b0);
      chk(n, 4);
      @(posedge ref_clk);
      refWant <= 1'b0;
      repeat (6) @(negedge ref_clk);
      do @(negedge ref_clk); while (refPin !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end while (refPin !== 1'b0);
      chk(n, 1);
      @(posedge ref_clk);
      refWant <= 1'b1;
      bus(1'b1, 8'h08, 32'h5800);
      mainWant <= 1'b1;
      do @(negedge ref_clk); while (oscRun !== 1'b0);
      chk({refOe, mainOe}, 2'b00);
      @(posedge ref_clk);
      bus(1'b1, 8'h20, 32'h111);
      chk(freqCode, 10'h2A5);
      mainWant <= 1'b0;
      do @(negedge ref_clk); while (oscRun !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end while (mainOe !== 1'b1);
      chk(n, 16);
      @(posedge ref_clk);
      bus(1'b1, 8'h08, 32'h3800);
      do @(negedge ref_clk); while (oscRun !== 1'b0);
      chk({refOe, mainOe}, 2'b00);
      complete_run;
   end
endmodule
